// file: design/fsei_regs.sv
// Purpose: Flash status, error configuration and error flag registers on AXI4-Lite
// Assumes: Sequencer, ECC and protection logic outside give one-cycle event pulses
// Notes: Launch pulse is a request; sequencer answers with CMD_DONE
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`include "fsei_params.svh"
module fsei_regs
    import fsei_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [5:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [5:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic CMD_DONE,
    input wire logic CMD_BUSY,
    input wire logic SEQ_VIOLATION,
    input wire logic ILLEGAL_CMD,
    input wire logic PROT_VIOLATION,
    input wire logic DOUBLE_FAULT,
    input wire logic SINGLE_FAULT,
    input wire logic RESET_DBL_FAULT,
    input wire logic [1:0] COMPLETION_ERR,
    output logic CMD_LAUNCH,
    output logic SEQ_ALLOWED,
    output logic CC_IRQ,
    output logic DF_IRQ,
    output logic SF_IRQ
);
    typedef struct packed {
        fsei_phase_type wph;
        fsei_phase_type rph;
        logic aw_got;
        logic w_got;
        logic [3:0] aw_idx;
        logic [7:0] wdata;
        logic wlane;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] config_r;
        logic [7:0] errcfg;
        logic cc;
        logic launch;
        logic [1:0] cstat;
        logic rst_done;
    } fsei_state_type;

    fsei_state_type st_r, st_nxt;
    logic ae_flag, pv_flag, df_flag, sf_flag;
    logic wr_fire;
    logic wr_ok;
    logic [7:0] wbyte;
    logic [7:0] status_view;
    logic [7:0] fault_view;
    logic [3:0] ar_idx;
    logic ae_set, pv_set;

    assign wr_fire = (st_r.wph == FSEI_IDLE) && st_r.aw_got && st_r.w_got;
    assign wr_ok = wr_fire && st_r.wlane;
    assign wbyte = st_r.wdata;
    assign ar_idx = S_AXI_ARADDR[5:2];
    assign ae_set = SEQ_VIOLATION | ILLEGAL_CMD;
    assign pv_set = PROT_VIOLATION;

    fsei_w1c u_ae (
        .CLK(CLK),
        .RST_B(RST_B),
        .set_in(ae_set),
        .clr_in(wr_ok && st_r.aw_idx == `FSEI_IDX_STATUS && wbyte[`FSEI_ST_AE]),
        .flag(ae_flag)
    );
    fsei_w1c u_pv (
        .CLK(CLK),
        .RST_B(RST_B),
        .set_in(pv_set),
        .clr_in(wr_ok && st_r.aw_idx == `FSEI_IDX_STATUS && wbyte[`FSEI_ST_PV]),
        .flag(pv_flag)
    );
    fsei_w1c u_df (
        .CLK(CLK),
        .RST_B(RST_B),
        .set_in(DOUBLE_FAULT),
        .clr_in(wr_ok && st_r.aw_idx == `FSEI_IDX_FAULT && wbyte[`FSEI_ERR_DF]),
        .flag(df_flag)
    );
    fsei_w1c u_sf (
        .CLK(CLK),
        .RST_B(RST_B),
        .set_in(SINGLE_FAULT && !st_r.config_r[`FSEI_CFG_SUPSF]),
        .clr_in(wr_ok && st_r.aw_idx == `FSEI_IDX_FAULT && wbyte[`FSEI_ERR_SF]),
        .flag(sf_flag)
    );

    // Bit 2 and unassigned bits are constant zero
    always_comb begin
        status_view = 8'h00;
        status_view[`FSEI_ST_CC] = st_r.cc;
        status_view[`FSEI_ST_AE] = ae_flag;
        status_view[`FSEI_ST_PV] = pv_flag;
        status_view[`FSEI_ST_BUSY] = CMD_BUSY && !st_r.cc;
        status_view[1:0] = st_r.cstat;
    end

    always_comb begin
        fault_view = 8'h00;
        fault_view[`FSEI_ERR_DF] = df_flag;
        fault_view[`FSEI_ERR_SF] = sf_flag;
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.launch = 1'b0;
        // Write channels, either order
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.aw_idx = S_AXI_AWADDR[5:2];
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = S_AXI_WDATA[7:0];
            st_nxt.wlane = S_AXI_WSTRB[0];
        end
        if (wr_fire) begin
            st_nxt.wph = FSEI_RESP;
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bresp = `FSEI_RESP_OKAY;
            if (st_r.aw_idx == `FSEI_IDX_CONFIG) begin
                if (st_r.wlane) begin
                    st_nxt.config_r = wbyte & `FSEI_CONFIG_MASK;
                end
            end else if (st_r.aw_idx == `FSEI_IDX_ERRCFG) begin
                if (st_r.wlane) begin
                    st_nxt.errcfg = wbyte & `FSEI_ERRCFG_MASK;
                end
            end else if (st_r.aw_idx == `FSEI_IDX_STATUS) begin
                // Launch refused while either error flag stands
                if (st_r.wlane && wbyte[`FSEI_ST_CC] && st_r.cc && !ae_flag && !pv_flag) begin
                    st_nxt.cc = 1'b0;
                    st_nxt.launch = 1'b1;
                    st_nxt.cstat = 2'h0;
                end
            end else if (st_r.aw_idx == `FSEI_IDX_FAULT) begin
                st_nxt.bresp = `FSEI_RESP_OKAY;
            end else begin
                st_nxt.bresp = `FSEI_RESP_SLVERR;
            end
        end
        if (st_r.wph == FSEI_RESP && S_AXI_BREADY) begin
            st_nxt.wph = FSEI_IDLE;
        end
        // Completion or violation ends the command
        if (!st_r.cc && (CMD_DONE || ae_set || pv_set)) begin
            st_nxt.cc = 1'b1;
            st_nxt.cstat = COMPLETION_ERR;
        end
        // Reset-time fault leaves error status in place of nominal value
        if (!st_r.rst_done) begin
            st_nxt.rst_done = 1'b1;
            st_nxt.cstat = RESET_DBL_FAULT ? (COMPLETION_ERR | 2'h2) : COMPLETION_ERR;
        end
        // Read channel
        if (st_r.rph == FSEI_IDLE && S_AXI_ARVALID) begin
            st_nxt.rph = FSEI_RESP;
            st_nxt.rresp = `FSEI_RESP_OKAY;
            st_nxt.rdata = 32'h0000_0000;
            if (ar_idx == `FSEI_IDX_CONFIG) begin
                st_nxt.rdata[7:0] = st_r.config_r;
            end else if (ar_idx == `FSEI_IDX_ERRCFG) begin
                st_nxt.rdata[7:0] = st_r.errcfg;
            end else if (ar_idx == `FSEI_IDX_STATUS) begin
                st_nxt.rdata[7:0] = status_view;
            end else if (ar_idx == `FSEI_IDX_FAULT) begin
                st_nxt.rdata[7:0] = fault_view;
            end else begin
                st_nxt.rresp = `FSEI_RESP_SLVERR;
            end
        end else if (st_r.rph == FSEI_RESP && S_AXI_RREADY) begin
            st_nxt.rph = FSEI_IDLE;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_r <= '0;
            st_r.cc <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign S_AXI_AWREADY = (st_r.wph == FSEI_IDLE) && !st_r.aw_got;
    assign S_AXI_WREADY = (st_r.wph == FSEI_IDLE) && !st_r.w_got;
    assign S_AXI_BVALID = (st_r.wph == FSEI_RESP);
    assign S_AXI_BRESP = st_r.bresp;
    assign S_AXI_ARREADY = (st_r.rph == FSEI_IDLE);
    assign S_AXI_RVALID = (st_r.rph == FSEI_RESP);
    assign S_AXI_RDATA = st_r.rdata;
    assign S_AXI_RRESP = st_r.rresp;
    assign CMD_LAUNCH = st_r.launch;
    assign SEQ_ALLOWED = !pv_flag;
    assign CC_IRQ = st_r.cc && st_r.config_r[`FSEI_CFG_COMMAND_COMPLETE_IRQ_ENABLE];
    assign DF_IRQ = df_flag && st_r.errcfg[`FSEI_ERR_DF];
    assign SF_IRQ = sf_flag && st_r.errcfg[`FSEI_ERR_SF];

    a_launch_blocked: assert property (@(posedge CLK) disable iff (!RST_B)
        (ae_flag || pv_flag) |=> !CMD_LAUNCH) else $error("launch while error flag set");
    a_launch_clears: assert property (@(posedge CLK) disable iff (!RST_B)
        CMD_LAUNCH |-> !st_r.cc) else $error("launch without clearing complete");
    a_df_irq_level: assert property (@(posedge CLK) disable iff (!RST_B)
        DOUBLE_FAULT && st_r.errcfg[`FSEI_ERR_DF] && !wr_fire |=> DF_IRQ)
        else $error("double fault irq missing");
    a_sf_irq_level: assert property (@(posedge CLK) disable iff (!RST_B)
        SINGLE_FAULT && !st_r.config_r[`FSEI_CFG_SUPSF] && st_r.errcfg[`FSEI_ERR_SF] && !wr_fire |=> SF_IRQ)
        else $error("single fault irq missing");
    a_cc_irq_level: assert property (@(posedge CLK) disable iff (!RST_B)
        $rose(CC_IRQ) |-> st_r.cc) else $error("complete irq without flag");
    a_ae_sets: assert property (@(posedge CLK) disable iff (!RST_B)
        ae_set |=> ae_flag) else $error("access error not set");
    a_pv_sets: assert property (@(posedge CLK) disable iff (!RST_B)
        pv_set |=> pv_flag ##0 !SEQ_ALLOWED) else $error("protection flag not set");
    a_ae_sticky: assert property (@(posedge CLK) disable iff (!RST_B)
        ae_flag && !(wr_ok && st_r.aw_idx == `FSEI_IDX_STATUS && wbyte[`FSEI_ST_AE]) |=> ae_flag)
        else $error("access error lost");
    a_pv_sticky: assert property (@(posedge CLK) disable iff (!RST_B)
        pv_flag && !(wr_ok && st_r.aw_idx == `FSEI_IDX_STATUS && wbyte[`FSEI_ST_PV]) |=> pv_flag)
        else $error("violation lost");
    a_cc_stays: assert property (@(posedge CLK) disable iff (!RST_B)
        !st_r.cc && !CMD_DONE && !ae_set && !pv_set |=> !st_r.cc) else $error("complete rose early");
    a_busy_view: assert property (@(posedge CLK) disable iff (!RST_B)
        status_view[`FSEI_ST_BUSY] |-> !status_view[`FSEI_ST_CC] && status_view[2] == 1'b0)
        else $error("busy view wrong");
    c_launch: cover property (@(posedge CLK) disable iff (!RST_B) CMD_LAUNCH ##[1:20] st_r.cc);
    c_blocked: cover property (@(posedge CLK) disable iff (!RST_B) wr_fire && ae_flag);
    c_df_irq: cover property (@(posedge CLK) disable iff (!RST_B) $rose(DF_IRQ));
    c_sf_hidden: cover property (@(posedge CLK) disable iff (!RST_B) SINGLE_FAULT && st_r.config_r[`FSEI_CFG_SUPSF]);
    c_reset_fault: cover property (@(posedge CLK) disable iff (!RST_B) !st_r.rst_done && RESET_DBL_FAULT);

    // Register and flag checks
    a_errcfg_write: assert property (@(posedge CLK) disable iff (!RST_B)
        wr_ok && st_r.aw_idx == `FSEI_IDX_ERRCFG |=> st_r.errcfg == ($past(wbyte) & `FSEI_ERRCFG_MASK))
        else $error("error config write lost");
    a_errcfg_hold: assert property (@(posedge CLK) disable iff (!RST_B)
        !(wr_ok && st_r.aw_idx == `FSEI_IDX_ERRCFG) |=> $stable(st_r.errcfg))
        else $error("error config changed without write");
    a_cfg_write: assert property (@(posedge CLK) disable iff (!RST_B)
        wr_ok && st_r.aw_idx == `FSEI_IDX_CONFIG |=> st_r.config_r == ($past(wbyte) & `FSEI_CONFIG_MASK))
        else $error("config write lost");
    a_launch_on_write: assert property (@(posedge CLK) disable iff (!RST_B)
        wr_ok && st_r.aw_idx == `FSEI_IDX_STATUS && wbyte[`FSEI_ST_CC] && st_r.cc && !ae_flag && !pv_flag
        |=> CMD_LAUNCH && !st_r.cc)
        else $error("launch write not taken");
    a_launch_pulse: assert property (@(posedge CLK) disable iff (!RST_B)
        CMD_LAUNCH |=> !CMD_LAUNCH)
        else $error("launch longer than one cycle");
    a_refused_keeps_cc: assert property (@(posedge CLK) disable iff (!RST_B)
        wr_fire && st_r.cc && (ae_flag || pv_flag) |=> st_r.cc)
        else $error("complete flag cleared while blocked");
    a_cc_rises: assert property (@(posedge CLK) disable iff (!RST_B)
        !st_r.cc && CMD_DONE |=> st_r.cc)
        else $error("complete flag not set at done");
    a_cstat_done: assert property (@(posedge CLK) disable iff (!RST_B)
        !st_r.cc && CMD_DONE && st_r.rst_done |=> st_r.cstat == $past(COMPLETION_ERR))
        else $error("completion status not captured");
    a_cstat_ro: assert property (@(posedge CLK) disable iff (!RST_B)
        st_r.rst_done && !(!st_r.cc && (CMD_DONE || ae_set || pv_set)) |=> CMD_LAUNCH || $stable(st_r.cstat))
        else $error("completion status changed by write");
    a_rst_fault: assert property (@(posedge CLK) disable iff (!RST_B)
        !st_r.rst_done && RESET_DBL_FAULT |=> st_r.cstat != 2'h0)
        else $error("reset fault not reported");
    a_busy_idle: assert property (@(posedge CLK) disable iff (!RST_B)
        st_r.cc |-> !status_view[`FSEI_ST_BUSY])
        else $error("busy while complete");
    a_busy_active: assert property (@(posedge CLK) disable iff (!RST_B)
        !st_r.cc && CMD_BUSY |-> status_view[`FSEI_ST_BUSY])
        else $error("busy missing");
    a_df_sets: assert property (@(posedge CLK) disable iff (!RST_B)
        DOUBLE_FAULT |=> df_flag)
        else $error("double fault flag not set");
    a_df_sticky: assert property (@(posedge CLK) disable iff (!RST_B)
        df_flag && !(wr_ok && st_r.aw_idx == `FSEI_IDX_FAULT && wbyte[`FSEI_ERR_DF]) |=> df_flag)
        else $error("double fault flag lost");
    a_sf_sets: assert property (@(posedge CLK) disable iff (!RST_B)
        SINGLE_FAULT && !st_r.config_r[`FSEI_CFG_SUPSF] |=> sf_flag)
        else $error("single fault flag not set");
    a_sf_masked: assert property (@(posedge CLK) disable iff (!RST_B)
        !sf_flag && !(SINGLE_FAULT && !st_r.config_r[`FSEI_CFG_SUPSF]) |=> !sf_flag)
        else $error("single fault flag set while suppressed");
    a_sf_sticky: assert property (@(posedge CLK) disable iff (!RST_B)
        sf_flag && !(wr_ok && st_r.aw_idx == `FSEI_IDX_FAULT && wbyte[`FSEI_ERR_SF]) |=> sf_flag)
        else $error("single fault flag lost");
    a_df_irq_drop: assert property (@(posedge CLK) disable iff (!RST_B)
        wr_ok && st_r.aw_idx == `FSEI_IDX_FAULT && wbyte[`FSEI_ERR_DF] && !DOUBLE_FAULT |=> !DF_IRQ)
        else $error("double fault irq stays after clear");
    a_sf_irq_drop: assert property (@(posedge CLK) disable iff (!RST_B)
        wr_ok && st_r.aw_idx == `FSEI_IDX_FAULT && wbyte[`FSEI_ERR_SF] && !SINGLE_FAULT |=> !SF_IRQ)
        else $error("single fault irq stays after clear");

    // Bus checks: answers stand until taken, one transfer each way
    a_bvalid_after: assert property (@(posedge CLK) disable iff (!RST_B)
        wr_fire |=> S_AXI_BVALID)
        else $error("write response missing");
    a_bvalid_hold: assert property (@(posedge CLK) disable iff (!RST_B)
        S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write response dropped");
    a_one_write: assert property (@(posedge CLK) disable iff (!RST_B)
        S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write taken during response");
    a_unmapped_write: assert property (@(posedge CLK) disable iff (!RST_B)
        wr_fire && (st_r.aw_idx < `FSEI_IDX_CONFIG || st_r.aw_idx > `FSEI_IDX_FAULT) |=> S_AXI_BRESP == `FSEI_RESP_SLVERR)
        else $error("unmapped write not refused");
    a_rvalid_after: assert property (@(posedge CLK) disable iff (!RST_B)
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read response missing");
    a_rvalid_hold: assert property (@(posedge CLK) disable iff (!RST_B)
        S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read response dropped");
    a_one_read: assert property (@(posedge CLK) disable iff (!RST_B)
        S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read taken during response");
    a_rresp_unmapped: assert property (@(posedge CLK) disable iff (!RST_B)
        S_AXI_ARVALID && S_AXI_ARREADY && (ar_idx < `FSEI_IDX_CONFIG || ar_idx > `FSEI_IDX_FAULT) |=> S_AXI_RRESP == `FSEI_RESP_SLVERR)
        else $error("unmapped read not refused");
    a_status_read: assert property (@(posedge CLK) disable iff (!RST_B)
        S_AXI_ARVALID && S_AXI_ARREADY && ar_idx == `FSEI_IDX_STATUS |=> S_AXI_RDATA[7:0] == $past(status_view))
        else $error("status read wrong");
    a_upper_zero: assert property (@(posedge CLK) disable iff (!RST_B)
        S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0000_00)
        else $error("upper read bits not zero");
endmodule

// file: design/fsei_params.svh
// Purpose: Constants for the flash status and error interrupt register bank
// Assumes: AXI4-Lite byte addresses are four times the register index
// Notes: Indices below are printed register indices
`ifndef FSEI_PARAMS_SVH
`define FSEI_PARAMS_SVH
`define FSEI_IDX_CONFIG 4'h4
`define FSEI_IDX_ERRCFG 4'h5
`define FSEI_IDX_STATUS 4'h6
`define FSEI_IDX_FAULT 4'h7
`define FSEI_CFG_COMMAND_COMPLETE_IRQ_ENABLE 7
`define FSEI_CFG_SUPSF 4
`define FSEI_ERR_DF 1
`define FSEI_ERR_SF 0
`define FSEI_ST_CC 7
`define FSEI_ST_AE 5
`define FSEI_ST_PV 4
`define FSEI_ST_BUSY 3
`define FSEI_ERRCFG_MASK 8'h03
`define FSEI_CONFIG_MASK 8'h90
`define FSEI_STATUS_RESET 8'h80
`define FSEI_RESP_OKAY 2'h0
`define FSEI_RESP_SLVERR 2'h2
`endif

// file: design/fsei_pkg.sv
// Purpose: Types for the flash status and error interrupt register bank
// Assumes: Used with fsei_params.svh
// Notes: Bus slave state only
package fsei_pkg;
    typedef enum logic [0:0] {FSEI_IDLE, FSEI_RESP} fsei_phase_type;
endpackage

// file: design/fsei_w1c.sv
// Purpose: One sticky flag, hardware set, write-one clear
// Assumes: Set wins over a clear in the same cycle
// Notes: Used for every error flag of the bank
`timescale 1ns/100ps
module fsei_w1c
    import fsei_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic set_in,
    input wire logic clr_in,
    output logic flag
);
    typedef struct packed {logic f;} fsei_w1c_type;
    fsei_w1c_type st_r, st_nxt;
    always_comb begin
        st_nxt = st_r;
        if (set_in) begin
            st_nxt.f = 1'b1;
        end else if (clr_in) begin
            st_nxt.f = 1'b0;
        end
    end
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign flag = st_r.f;
endmodule

// file: dv/fsei_tb.sv
// Purpose: Self-checking bench for the flash status and error register bank
// Assumes: Byte addresses are four times the register index, lane 0 only
// Notes: Event inputs are one-cycle pulses driven from one vector
`timescale 1ns/100ps
module testbench;
    import fsei_pkg::*;
    localparam logic [5:0] A_CFG = 6'h10;
    localparam logic [5:0] A_ERR = 6'h14;
    localparam logic [5:0] A_ST = 6'h18;
    localparam logic [5:0] A_FLT = 6'h1c;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [5:0] awaddr = 6'h00;
    logic [5:0] araddr = 6'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic cmd_busy = 1'b0;
    logic rst_dbl = 1'b0;
    logic [1:0] comp_err = 2'h0;
    logic [5:0] ev_v = 6'h00;
    logic awready, wready, bvalid, arready, rvalid, launch, seq_ok, cc_irq, df_irq, sf_irq;
    logic [1:0] bresp, rresp, ce;
    logic [31:0] rdata, rd;
    logic [1:0] rsp;
    logic [1:0] rr;
    logic [7:0] en;
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_launch = 0;
    int l0 = 0;

    always #25 clk = ~clk;

    fsei_regs i_dut (.CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .CMD_DONE(ev_v[0]), .CMD_BUSY(cmd_busy), .SEQ_VIOLATION(ev_v[1]),
        .ILLEGAL_CMD(ev_v[2]), .PROT_VIOLATION(ev_v[3]), .DOUBLE_FAULT(ev_v[4]), .SINGLE_FAULT(ev_v[5]),
        .RESET_DBL_FAULT(rst_dbl), .COMPLETION_ERR(comp_err), .CMD_LAUNCH(launch), .SEQ_ALLOWED(seq_ok),
        .CC_IRQ(cc_irq), .DF_IRQ(df_irq), .SF_IRQ(sf_irq));

    function automatic logic [31:0] st(input logic cc, ae, pv, bz, input logic [1:0] mg);
        return {24'h0000_00, cc, 1'b0, ae, pv, bz, 1'b0, mg};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Master waits on the slave's own handshake; only the cycle ceiling ends a hang
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                rsp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rchk(input logic [5:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata;
                rr = rresp;
                rready <= 1'b0;
                break;
            end
        end
        chk(rd, exp, what);
    endtask

    task automatic pulse(input int k);
        @(posedge clk);
        ev_v <= 6'h01 << k;
        @(posedge clk);
        ev_v <= 6'h00;
        @(negedge clk);
    endtask

    task automatic irqs(input logic [2:0] exp);
        @(negedge clk);
        chk({29'h0, cc_irq, df_irq, sf_irq}, {29'h0, exp}, "irq levels");
    endtask

    always @(posedge clk) begin
        cyc++;
        if (launch === 1'b1) n_launch++;
        if (cyc == 5000) begin
            failures++;
            final_report;
        end
    end

    initial begin
        void'($urandom(32'he113));
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rchk(A_ST, st(1, 0, 0, 0, 2'h0), "status reset");
        rchk(A_ERR, 32'h0000_0000, "errcfg reset");
        wr(A_ST, 32'h0000_0004);
        rchk(A_ST, st(1, 0, 0, 0, 2'h0), "reserved bit");
        wr(6'h00, 32'h0000_00ff);
        chk({30'h0, rsp}, 32'h0000_0002, "unmapped resp");
        rchk(6'h00, 32'h0000_0000, "unmapped read");
        chk({30'h0, rr}, 32'h0000_0002, "unmapped rresp");
        $display("test reset and map done");
        repeat (4) begin
            en = 8'($urandom);
            wr(A_ERR, {24'h0000_00, en});
            chk({30'h0, rsp}, 32'h0000_0000, "errcfg resp");
            rchk(A_ERR, {24'h0000_00, en & 8'h03}, "errcfg rw");
            pulse(4);
            pulse(5);
            irqs({1'b0, en[1:0]});
            wr(A_FLT, 32'h0000_0000);
            rchk(A_FLT, 32'h0000_0003, "fault flags");
            wr(A_FLT, 32'h0000_0003);
            irqs(3'b000);
        end
        wr(A_CFG, 32'h0000_00ff);
        rchk(A_CFG, 32'h0000_0090, "config rw");
        pulse(5);
        rchk(A_FLT, 32'h0000_0000, "suppressed single");
        irqs(3'b100);
        $display("test fault irq done");
        l0 = n_launch;
        wr(A_ST, 32'h0000_0080);
        cmd_busy <= 1'b1;
        irqs(3'b000);
        chk(32'(n_launch - l0), 32'd1, "launch count");
        rchk(A_ST, st(0, 0, 0, 1, 2'h0), "busy");
        ce = 2'($urandom);
        comp_err <= ce;
        cmd_busy <= 1'b0;
        pulse(0);
        rchk(A_ST, st(1, 0, 0, 0, ce), "done");
        irqs(3'b100);
        $display("test launch done");
        for (int k = 1; k < 4; k++) begin
            l0 = n_launch;
            pulse(k);
            chk({31'h0, seq_ok}, {31'h0, k != 3}, "seq allowed");
            wr(A_ST, 32'h0000_0080);
            wr(A_ST, 32'h0000_0000);
            chk(32'(n_launch - l0), 32'd0, "blocked launch");
            rchk(A_ST, st(1, k != 3, k == 3, 0, ce), "error flag");
            wr(A_ST, k == 3 ? 32'h0000_0010 : 32'h0000_0020);
            rchk(A_ST, st(1, 0, 0, 0, ce), "error cleared");
        end
        $display("test errors done");
        @(posedge clk);
        rst_dbl <= 1'b1;
        comp_err <= 2'h0;
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rchk(A_ST, st(1, 0, 0, 0, 2'h2), "reset fault");
        $display("test reset fault done");
        final_report;
    end
endmodule
